// File: if_packet_trailer_builder.sv
// IF data packet builder: header, sign-extended samples and trailer word
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module if_packet_trailer_builder
    import trailer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic pll_locked,
    input wire logic nb_filter_settled,
    input wire logic sample_valid,
    input wire logic [SAMPLE_WIDTH-1:0] sample_data,
    input wire logic sample_over_range,
    input wire logic capture_overflow,
    output logic [31:0] pkt_data,
    output logic pkt_valid,
    output logic pkt_last,
    input wire logic pkt_ready,
    output logic irq
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HEADER,
        ST_PAYLOAD,
        ST_TRAILER
    } build_state_e;

    // Register state
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [FLAG_COUNT-1:0] flag_enable;
    logic [LEN_WIDTH-1:0] payload_len;
    logic [EV_COUNT-1:0] status;
    logic [EV_COUNT-1:0] irq_mask;

    // Bus pipeline
    logic wr_pending;
    logic [REG_ADDR_BITS-1:0] wr_addr;

    // Packet state
    build_state_e state;
    logic [LEN_WIDTH-1:0] word_cnt;
    logic [3:0] pkt_count;
    logic loss_pending;
    logic loss_this_pkt;
    logic lock_ok;
    logic settle_ok;
    logic over_seen;
    logic locked_s;
    logic settled_s;
    logic locked_d;

    wire stream_en = ctrl[CTRL_STREAM_EN_BIT];
    wire ext_range_mode = ctrl[CTRL_EXT_RANGE_BIT];
    wire spec_inverted = ctrl[CTRL_SPEC_INV_BIT];

    // Lock and settle status arrive from other clock domains
    level_sync #(.WIDTH(2)) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({pll_locked, nb_filter_settled}),
        .q({locked_s, settled_s})
    );

    // AHB-Lite decode
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_start = addr_phase && hwrite;
    wire rd_start = addr_phase && !hwrite;
    wire [REG_ADDR_BITS-1:0] rd_addr = haddr[REG_ADDR_BITS-1:0];

    wire wr_ctrl = wr_pending && (wr_addr == CTRL_OFFSET);
    wire wr_enable = wr_pending && (wr_addr == FLAG_ENABLE_OFFSET);
    wire wr_len = wr_pending && (wr_addr == PAYLOAD_LEN_OFFSET);
    wire wr_status = wr_pending && (wr_addr == STATUS_OFFSET);
    wire wr_mask = wr_pending && (wr_addr == IRQ_MASK_OFFSET);

    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            CTRL_OFFSET: rd_mux = {29'h0, ctrl};
            FLAG_ENABLE_OFFSET: rd_mux = {27'h0, flag_enable};
            PAYLOAD_LEN_OFFSET: rd_mux = {16'h0, payload_len};
            STATUS_OFFSET: rd_mux = {28'h0, status};
            IRQ_MASK_OFFSET: rd_mux = {28'h0, irq_mask};
            STATE_OFFSET: rd_mux = {word_cnt, 8'h00, pkt_count, loss_pending, lock_ok, state};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pending <= wr_start;
            if (wr_start) begin
                wr_addr <= rd_addr;
            end
            if (rd_start) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Output stage and drop detect
    wire out_free = !pkt_valid || pkt_ready;
    wire take_sample = (state == ST_PAYLOAD) && sample_valid && out_free;
    // No buffer: a sample that cannot be placed is lost
    wire drop_sample = stream_en && sample_valid && !take_sample;
    wire last_payload = (word_cnt == payload_len - 16'h0001);
    wire emit_header = (state == ST_HEADER) && out_free;
    wire emit_trailer = (state == ST_TRAILER) && out_free;
    wire lock_lost_edge = locked_d && !locked_s;

    // 16-bit size covering header, payload and trailer
    wire [LEN_WIDTH-1:0] pkt_size = payload_len + LEN_WIDTH'(HEADER_WORDS + TRAILER_WORDS);

    // Built from the package layout so the trailer-present bit sits where receivers look for it
    logic [31:0] header_word;
    always_comb begin
        header_word = 32'h0000_0000;
        header_word[HDR_TYPE_LSB +: 4] = HDR_PACKET_TYPE;
        header_word[HDR_TRAILER_BIT] = 1'b1;
        header_word[HDR_COUNT_LSB +: 4] = pkt_count;
        header_word[LEN_WIDTH-1:0] = pkt_size;
    end

    wire [31:0] sample_word = {{(32 - SAMPLE_WIDTH){sample_data[SAMPLE_WIDTH-1]}}, sample_data};

    // Trailer flags
    trailer_flags_if flags_bus ();
    logic [31:0] trailer_word;

    assign flags_bus.enable = flag_enable;
    // Current-cycle lock is folded in so an unlock on the last cycle still counts
    wire lock_final = lock_ok && locked_s;
    wire settle_final = settle_ok && settled_s;
    assign flags_bus.indicator[FLAG_DV] = lock_final && (!ext_range_mode || settle_final);
    assign flags_bus.indicator[FLAG_RL] = lock_final;
    assign flags_bus.indicator[FLAG_SI] = spec_inverted;
    assign flags_bus.indicator[FLAG_OR] = over_seen;
    assign flags_bus.indicator[FLAG_SL] = loss_this_pkt;

    trailer_packer u_packer (
        .flags(flags_bus),
        .word(trailer_word)
    );

    // Packet state machine
    build_state_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (stream_en) begin
                    next_state = ST_HEADER;
                end
            end
            ST_HEADER: begin
                if (out_free) begin
                    next_state = (payload_len == 16'h0000) ? ST_TRAILER : ST_PAYLOAD;
                end
            end
            ST_PAYLOAD: begin
                if (take_sample && last_payload) begin
                    next_state = ST_TRAILER;
                end
            end
            ST_TRAILER: begin
                if (out_free) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pkt_data <= 32'h0000_0000;
            pkt_valid <= 1'b0;
            pkt_last <= 1'b0;
        end else if (emit_header) begin
            pkt_data <= header_word;
            pkt_valid <= 1'b1;
            pkt_last <= 1'b0;
        end else if (take_sample) begin
            pkt_data <= sample_word;
            pkt_valid <= 1'b1;
            pkt_last <= 1'b0;
        end else if (emit_trailer) begin
            pkt_data <= trailer_word;
            pkt_valid <= 1'b1;
            pkt_last <= 1'b1;
        end else if (pkt_ready) begin
            pkt_valid <= 1'b0;
            pkt_last <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_cnt <= 16'h0000;
            pkt_count <= 4'h0;
        end else begin
            if (emit_header) begin
                word_cnt <= 16'h0000;
            end else if (take_sample) begin
                word_cnt <= word_cnt + 16'h0001;
            end
            if (emit_trailer) begin
                pkt_count <= pkt_count + 4'h1;
            end
        end
    end

    // Per-packet condition tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_ok <= 1'b0;
            settle_ok <= 1'b0;
            over_seen <= 1'b0;
            loss_this_pkt <= 1'b0;
            locked_d <= 1'b0;
        end else begin
            locked_d <= locked_s;
            if (emit_header) begin
                lock_ok <= locked_s;
                settle_ok <= settled_s;
                over_seen <= 1'b0;
                loss_this_pkt <= loss_pending;
            end else begin
                lock_ok <= lock_ok && locked_s;
                settle_ok <= settle_ok && settled_s;
                if (take_sample && sample_over_range) begin
                    over_seen <= 1'b1;
                end
            end
        end
    end

    // Loss is reported in the next header's packet; a new loss wins over the hand-off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_pending <= 1'b0;
        end else if (drop_sample || capture_overflow) begin
            loss_pending <= 1'b1;
        end else if (emit_header) begin
            loss_pending <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            flag_enable <= FLAG_ENABLE_RESET;
            payload_len <= PAYLOAD_LEN_RESET;
            irq_mask <= EV_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata[CTRL_WIDTH-1:0];
            end
            if (wr_enable) begin
                flag_enable <= hwdata[FLAG_COUNT-1:0];
            end
            if (wr_len) begin
                payload_len <= hwdata[LEN_WIDTH-1:0];
            end
            if (wr_mask) begin
                irq_mask <= hwdata[EV_COUNT-1:0];
            end
        end
    end

    // Events and interrupt
    logic [EV_COUNT-1:0] ev_set;
    logic [EV_COUNT-1:0] ev_clr;
    logic [EV_COUNT-1:0] next_status;
    always_comb begin
        ev_set = '0;
        ev_set[EV_PACKET] = emit_trailer;
        ev_set[EV_DROP] = drop_sample || capture_overflow;
        ev_set[EV_OVER] = take_sample && sample_over_range;
        ev_set[EV_UNLOCK] = lock_lost_edge;
        ev_clr = wr_status ? hwdata[EV_COUNT-1:0] : '0;
        // A set in the same cycle as its clear is kept
        next_status = (status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= EV_RESET;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & irq_mask);
        end
    end

    // Byte-size writes and hsize are not checked; only full-word transfers are expected
    wire unused_bus = &{1'b0, hsize, haddr[31:REG_ADDR_BITS]};
endmodule : if_packet_trailer_builder
`default_nettype wire

// File: trailer_pkg.sv
// Constants shared by the IF packet trailer builder and its helpers
`default_nettype none
package trailer_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] FLAG_ENABLE_OFFSET = 8'h04;
    localparam logic [7:0] PAYLOAD_LEN_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
    localparam logic [7:0] STATE_OFFSET = 8'h14;
    localparam int REG_ADDR_BITS = 8;

    // Control register fields
    localparam int CTRL_STREAM_EN_BIT = 0;
    localparam int CTRL_EXT_RANGE_BIT = 1;
    localparam int CTRL_SPEC_INV_BIT = 2;
    localparam int CTRL_WIDTH = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Flag order inside the five-bit enable and indicator vectors
    localparam int FLAG_COUNT = 5;
    localparam int FLAG_SL = 0;
    localparam int FLAG_OR = 1;
    localparam int FLAG_SI = 2;
    localparam int FLAG_RL = 3;
    localparam int FLAG_DV = 4;
    localparam logic [4:0] FLAG_ENABLE_RESET = 5'h1F;

    // Trailer layout
    localparam int TRAILER_ENABLE_POS [FLAG_COUNT] = '{24, 25, 26, 29, 30};
    localparam int TRAILER_INDICATOR_SHIFT = 12;
    localparam int TRAILER_CTX_VALID_BIT = 7;

    // Header layout
    localparam logic [3:0] HDR_PACKET_TYPE = 4'h1;
    localparam int HDR_TYPE_LSB = 28;
    localparam int HDR_TRAILER_BIT = 26;
    localparam int HDR_COUNT_LSB = 16;
    localparam int HEADER_WORDS = 1;
    localparam int TRAILER_WORDS = 1;

    // Payload length register
    localparam int LEN_WIDTH = 16;
    localparam logic [15:0] PAYLOAD_LEN_RESET = 16'h0020;

    // Sample format
    localparam int SAMPLE_WIDTH = 24;

    // Sticky event bits
    localparam int EV_PACKET = 0;
    localparam int EV_DROP = 1;
    localparam int EV_OVER = 2;
    localparam int EV_UNLOCK = 3;
    localparam int EV_COUNT = 4;
    localparam logic [3:0] EV_RESET = 4'h0;
endpackage : trailer_pkg
`default_nettype wire

// File: trailer_flags_if.sv
// Enable and indicator flags passed from the builder to the trailer packer
`timescale 1ns/1ns
`default_nettype none
interface trailer_flags_if;
    import trailer_pkg::*;
    logic [FLAG_COUNT-1:0] enable;
    logic [FLAG_COUNT-1:0] indicator;
    modport source (output enable, output indicator);
    modport packer (input enable, input indicator);
endinterface : trailer_flags_if
`default_nettype wire

// File: level_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : level_sync
`default_nettype wire

// File: trailer_packer.sv
// Packs enable and indicator flags into the 32-bit trailer word
`timescale 1ns/1ns
`default_nettype none
module trailer_packer
    import trailer_pkg::*;
(
    trailer_flags_if.packer flags,
    output logic [31:0] word
);
    always_comb begin
        word = 32'h0000_0000;
        for (int i = 0; i < FLAG_COUNT; i++) begin
            word[TRAILER_ENABLE_POS[i]] = flags.enable[i];
            // A disabled indicator stays zero so it makes no claim
            word[TRAILER_ENABLE_POS[i] - TRAILER_INDICATOR_SHIFT] =
                flags.enable[i] & flags.indicator[i];
        end
        word[TRAILER_CTX_VALID_BIT] = 1'b0;
    end
endmodule : trailer_packer
`default_nettype wire

// File: if_packet_trailer_builder_asserts.sv
// Concurrent checks on the packet stream and bus ports of the trailer builder
`timescale 1ns/1ns
`default_nettype none
module if_packet_trailer_builder_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pll_locked,
    input wire logic [31:0] pkt_data,
    input wire logic pkt_valid,
    input wire logic pkt_last,
    input wire logic pkt_ready
);
    logic hdr_next;
    logic [15:0] wc;
    logic [15:0] size_q;
    // Tracks packet position so payload words can be told from headers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hdr_next <= 1'b1;
            wc <= 16'h0000;
            size_q <= 16'h0000;
        end else if (pkt_valid && pkt_ready) begin
            hdr_next <= pkt_last;
            wc <= pkt_last ? 16'h0000 : wc + 16'h0001;
            size_q <= hdr_next ? pkt_data[15:0] : size_q;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_TRL_UNUSED: assert property (pkt_valid && pkt_last |->
        {pkt_data[31], pkt_data[28:27], pkt_data[23:19], pkt_data[16:15], pkt_data[11:8]} == 14'h0000)
        else $error("trailer has a spare bit set");
    AST_CTX_VALID: assert property (pkt_valid && pkt_last |-> !pkt_data[7])
        else $error("trailer context valid bit set");
    AST_CTX_COUNT: assert property (pkt_valid && pkt_last |-> pkt_data[6:0] == 7'h00)
        else $error("trailer context count not zero");
    AST_IND_GATED: assert property (pkt_valid && pkt_last |-> (pkt_data[18:12] & ~pkt_data[30:24]) == 7'h00)
        else $error("indicator set without its enable");
    AST_LOCK_LOST: assert property ((!pll_locked)[*6] ##0 $rose(pkt_valid && pkt_last) |->
        pkt_data[18:17] == 2'h0)
        else $error("valid or lock indicator set while unlocked");
    AST_SIGN_EXT: assert property (pkt_valid && !pkt_last && !hdr_next |->
        pkt_data[31:24] == {8{pkt_data[23]}})
        else $error("payload word not sign extended");
    AST_HDR_TRAILER: assert property (pkt_valid && hdr_next |-> pkt_data[26])
        else $error("header trailer flag clear");
    AST_PKT_SIZE: assert property (pkt_valid && pkt_ready && pkt_last |-> wc + 16'h0001 == size_q)
        else $error("trailer position disagrees with packet size");
    AST_HOLD: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) && $stable(pkt_last))
        else $error("stalled stream word changed");
    AST_OKAY: assert property (1'b1 |-> hreadyout && !hresp)
        else $error("bus not ready or error response");
    COV_STALL: cover property (pkt_valid && pkt_last && !pkt_ready);
    COV_LOSS: cover property (pkt_valid && pkt_last && pkt_data[12]);
    COV_DATA_OK: cover property (pkt_valid && pkt_last && pkt_data[18]);
endmodule : if_packet_trailer_builder_asserts
bind if_packet_trailer_builder if_packet_trailer_builder_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .pll_locked(pll_locked), .pkt_data(pkt_data),
    .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
`default_nettype wire

// File: pkt_receiver.sv
// Host-side receiver model collecting packet words, with an optional stall
`timescale 1ns/1ns
`default_nettype none
module pkt_receiver (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] pkt_data,
    input wire logic pkt_valid,
    input wire logic pkt_last,
    input wire logic stall,
    output logic pkt_ready
);
    logic [31:0] words [$];
    logic inverted = 1'b0;
    // Toggling ready keeps a held word visible across several edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pkt_ready <= 1'b0;
        end else begin
            pkt_ready <= stall ? !pkt_ready : 1'b1;
        end
    end
    always @(posedge hclk) begin
        if (hresetn && pkt_valid && pkt_ready) begin
            words.push_back(pkt_data);
            // Software reverses bins only when the indicator is enabled
            if (pkt_last) inverted = pkt_data[26] & pkt_data[14];
        end
    end
endmodule : pkt_receiver
`default_nettype wire

// File: if_packet_trailer_builder_tb.sv
// Self-checking bench: bus access, packet contents, trailer flags and interrupt
`timescale 1ns/1ns
`default_nettype none
module if_packet_trailer_builder_tb;
    import trailer_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic pll_locked = 1'b1;
    logic nb_filter_settled = 1'b1;
    logic sample_valid = 1'b0;
    logic [23:0] sample_data = 24'h000000;
    logic sample_over_range = 1'b0;
    logic capture_overflow = 1'b0;
    logic [31:0] pkt_data;
    logic pkt_valid;
    logic pkt_last;
    logic pkt_ready;
    logic stall = 1'b0;
    logic irq;
    logic [31:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    int base = 0;
    logic [7:0] ra [5] = '{CTRL_OFFSET, FLAG_ENABLE_OFFSET, PAYLOAD_LEN_OFFSET, IRQ_MASK_OFFSET, 8'h18};
    logic [31:0] re [5] = '{32'h0, 32'h1F, 32'h20, 32'h0, 32'h0};
    assign hready = hreadyout;
    always #4 hclk = ~hclk;

    if_packet_trailer_builder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pll_locked(pll_locked),
        .nb_filter_settled(nb_filter_settled), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_over_range(sample_over_range), .capture_overflow(capture_overflow),
        .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready), .irq(irq));
    pkt_receiver rx (.hclk(hclk), .hresetn(hresetn), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
        .pkt_last(pkt_last), .stall(stall), .pkt_ready(pkt_ready));

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Single word transfer; read data is taken at the edge ending the data phase
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask : ahb

    // Samples go in only after the header has left, so none is dropped
    task pkt(input logic [31:0] hdr, input logic [23:0] s0, input logic [23:0] s1, input logic ov,
        input logic ofl, input logic slow, input logic [31:0] tr);
        while (rx.words.size() < base + 1) @(posedge hclk);
        @(posedge hclk);
        sample_valid <= 1'b1;
        sample_data <= s0;
        sample_over_range <= ov;
        capture_overflow <= ofl;
        @(posedge hclk);
        sample_data <= s1;
        sample_over_range <= 1'b0;
        capture_overflow <= 1'b0;
        @(posedge hclk);
        sample_valid <= 1'b0;
        // Stall starts once the samples are in, so the trailer is held but nothing drops
        stall <= slow;
        repeat (2) @(posedge hclk);
        while (rx.words.size() < base + 4) @(posedge hclk);
        check(rx.words[base], hdr);
        check(rx.words[base + 1], {{8{s0[23]}}, s0});
        check(rx.words[base + 2], {{8{s1[23]}}, s1});
        check(rx.words[base + 3], tr);
        base += 4;
    endtask : pkt

    initial begin
        #100000;
        mismatches++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            check(rd, re[i]);
        end
        $display("test reset_values done");
        ahb(1'b1, PAYLOAD_LEN_OFFSET, 32'h00000002);
        ahb(1'b1, CTRL_OFFSET, 32'h00000005);
        pkt(32'h14000004, 24'h800034, 24'h000018, 1'b1, 1'b0, 1'b0, 32'h67066000);
        check({31'h0, rx.inverted}, 32'h1);
        $display("test valid_packet done");
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd, 32'h5);
        check({31'h0, irq}, 32'h0);
        ahb(1'b1, IRQ_MASK_OFFSET, 32'h1);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        ahb(1'b1, STATUS_OFFSET, 32'h5);
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test irq done");
        nb_filter_settled <= 1'b0;
        ahb(1'b1, CTRL_OFFSET, 32'h00000007);
        pkt(32'h14010004, 24'h123456, 24'hFEDCBA, 1'b0, 1'b0, 1'b0, 32'h67024000);
        $display("test unsettled_packet done");
        nb_filter_settled <= 1'b1;
        pll_locked <= 1'b0;
        pkt(32'h14020004, 24'h7FFFFF, 24'hFFFFFF, 1'b0, 1'b1, 1'b0, 32'h67004000);
        $display("test unlocked_packet done");
        ahb(1'b1, FLAG_ENABLE_OFFSET, 32'h1);
        pkt(32'h14030004, 24'h800034, 24'h000018, 1'b0, 1'b0, 1'b1, 32'h01001000);
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd, 32'hB);
        check({31'h0, irq}, 32'h1);
        $display("test loss_packet done");
        end_sim;
    end
endmodule : if_packet_trailer_builder_tb
`default_nettype wire
